// file: inc/dswd_pkg.sv
package dswd_pkg;
  // Frame layout
  localparam int CMD_BITS   = 24;
  localparam int CHECK_BITS = 8;
  localparam int CHECKED_BITS = 32;
  localparam int RW_POS     = 23;
  localparam int DEV_HI_POS = 22;
  localparam int DEV_LO_POS = 21;
  localparam int RSEL_MSB   = 20;
  localparam int RSEL_LSB   = 18;
  localparam int CH_MSB     = 17;
  localparam int CH_LSB     = 16;
  localparam int CSEL_MSB   = 15;
  localparam int CSEL_LSB   = 13;
  localparam int CDATA_MSB  = 12;
  // Register-select codes
  localparam logic [2:0] RSEL_CODE     = 3'h0;
  localparam logic [2:0] RSEL_NOP      = 3'h1;
  localparam logic [2:0] RSEL_GAIN     = 3'h2;
  localparam logic [2:0] RSEL_GAIN_ALL = 3'h3;
  localparam logic [2:0] RSEL_OFS      = 3'h4;
  localparam logic [2:0] RSEL_OFS_ALL  = 3'h5;
  localparam logic [2:0] RSEL_CLR      = 3'h6;
  localparam logic [2:0] RSEL_CTRL     = 3'h7;
  // Control-target codes
  localparam logic [2:0] CSEL_CHCTRL = 3'h2;
  localparam logic [2:0] CSEL_BOOST  = 3'h3;
  // Reset values
  localparam logic [15:0] CODE_RST  = 16'h0000;
  localparam logic [15:0] GAIN_RST  = 16'hFFFF;
  localparam logic [15:0] OFS_RST   = 16'h8000;
  localparam logic [15:0] CLR_RST   = 16'h0000;
  localparam logic [12:0] CTRL_RST  = 13'h0000;
  // Host APB map
  localparam logic [7:0] A_CTRL  = 8'h00;
  localparam logic [7:0] A_WORD  = 8'h04;
  localparam logic [7:0] A_CHECK = 8'h08;
  localparam logic [7:0] A_STAT  = 8'h0C;
  localparam int START_POS  = 0;
  localparam int CHK_EN_POS = 1;
  localparam int BUSY_POS   = 0;
  localparam int SETTLE_POS = 1;
  localparam int PEND_POS   = 2;
  // Timing
  localparam int CLK_MHZ    = 250;
  localparam int SETTLE_US  = 200;
  localparam int SETTLE_CYC = SETTLE_US * CLK_MHZ;
  localparam int SCLK_HALF  = 4;
endpackage : dswd_pkg

// file: inc/dswd_if.sv
`timescale 1ns/1ps
`default_nettype none
interface dswd_if;
  logic sclk;
  logic sync_n;
  logic sdin;
  modport host_mp (output sclk, output sync_n, output sdin);
  modport dev_mp  (input sclk, input sync_n, input sdin);
endinterface : dswd_if
`default_nettype wire

// file: hw/dswd_sync.sv
`timescale 1ns/1ps
`default_nettype none
module dswd_sync #(
  parameter int WIDTH = 1
) (
  input  wire logic             pclk,
  input  wire logic             presetn,
  input  wire logic [WIDTH-1:0] async_in,
  output var  logic [WIDTH-1:0] sync_out
);
  logic [WIDTH-1:0] meta_ff;

  for (genvar i = 0; i < WIDTH; i++)
  begin : g_bit
    always_ff @(posedge pclk or negedge presetn)
    begin
      if (!presetn)
      begin
        meta_ff[i]  <= 1'b1;
        sync_out[i] <= 1'b1;
      end
      else
      begin
        meta_ff[i]  <= async_in[i];
        sync_out[i] <= meta_ff[i];
      end
    end
  end
endmodule : dswd_sync
`default_nettype wire

// file: hw/dswd_device.sv
`timescale 1ns/1ps
`default_nettype none
module dswd_device (
  input  wire logic              pclk,
  input  wire logic              presetn,
  dswd_if.dev_mp                 link,
  input  wire logic              strap_pin_hi,
  input  wire logic              strap_pin_lo,
  input  wire logic              frame_check_enable,
  output var  logic [3:0][15:0]  channel_output_code,
  output var  logic [3:0][15:0]  gain_trim,
  output var  logic [3:0][15:0]  offset_trim,
  output var  logic [3:0][15:0]  clear_code,
  output var  logic [3:0][12:0]  channel_control,
  output var  logic [12:0]       boost_config,
  output var  logic              ctrl_wr_pulse,
  output var  logic [2:0]        ctrl_wr_target,
  output var  logic [1:0]        ctrl_wr_channel,
  output var  logic [12:0]       ctrl_wr_data,
  output var  logic              read_pulse,
  output var  logic [23:0]       read_word,
  output var  logic [7:0]        check_code,
  output var  logic              frame_drop_pulse
);
  logic [4:0]  pins_s;
  logic        sclk_s;
  logic        sync_n_s;
  logic        sdin_s;
  logic        strap_hi_s;
  logic        strap_lo_s;
  logic        sclk_d_ff;
  logic        sync_n_d_ff;
  logic [31:0] shift_ff;
  logic [5:0]  count_ff;
  logic        sclk_fall;
  logic        frame_start;
  logic        frame_end;
  logic [5:0]  frame_len;
  logic [23:0] cmd_word;
  logic        frame_ok;
  logic        addr_hit;
  logic        wr_en;
  logic [2:0]  rsel;
  logic [1:0]  chan;
  logic [15:0] payload;

  // Pins come from another party's timing and are resynchronised
  dswd_sync #(
    .WIDTH (5)
  ) u_sync (
    .pclk     (pclk),
    .presetn  (presetn),
    .async_in ({link.sclk, link.sync_n, link.sdin, strap_pin_hi, strap_pin_lo}),
    .sync_out (pins_s)
  );

  assign sclk_s     = pins_s[4];
  assign sync_n_s   = pins_s[3];
  assign sdin_s     = pins_s[2];
  assign strap_hi_s = pins_s[1];
  assign strap_lo_s = pins_s[0];

  assign sclk_fall   = sclk_d_ff & ~sclk_s;
  assign frame_start = sync_n_d_ff & ~sync_n_s;
  assign frame_end   = ~sync_n_d_ff & sync_n_s;

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      sclk_d_ff   <= 1'b1;
      sync_n_d_ff <= 1'b1;
    end
    else
    begin
      sclk_d_ff   <= sclk_s;
      sync_n_d_ff <= sync_n_s;
    end
  end

  // Data is sampled on the falling serial clock edge while the frame is open
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      shift_ff <= '0;
    else if (!sync_n_s && sclk_fall)
      shift_ff <= {shift_ff[30:0], sdin_s};
  end

  // Saturating count so an overlong frame can never alias to a valid length
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      count_ff <= '0;
    else if (frame_start)
      count_ff <= '0;
    else if (!sync_n_s && sclk_fall && count_ff != 6'h3F)
      count_ff <= count_ff + 6'h01;
  end

  assign frame_len = frame_check_enable ? 6'(dswd_pkg::CHECKED_BITS)
                                        : 6'(dswd_pkg::CMD_BITS);
  assign cmd_word  = frame_check_enable ? shift_ff[31:8] : shift_ff[23:0];
  assign frame_ok  = frame_end && (count_ff == frame_len);
  assign addr_hit  = (cmd_word[dswd_pkg::DEV_HI_POS] == strap_hi_s) &&
                     (cmd_word[dswd_pkg::DEV_LO_POS] == strap_lo_s);
  assign wr_en     = frame_ok && addr_hit && !cmd_word[dswd_pkg::RW_POS];
  assign rsel      = cmd_word[dswd_pkg::RSEL_MSB:dswd_pkg::RSEL_LSB];
  assign chan      = cmd_word[dswd_pkg::CH_MSB:dswd_pkg::CH_LSB];
  assign payload   = cmd_word[15:0];

  // Per-channel data registers; all-channel codes ignore the channel bits
  for (genvar ch = 0; ch < 4; ch++)
  begin : g_chan
    logic hit;
    logic ctrl_hit;
    assign hit      = wr_en && (chan == 2'(ch));
    assign ctrl_hit = hit && (rsel == dswd_pkg::RSEL_CTRL) &&
                      (cmd_word[dswd_pkg::CSEL_MSB:dswd_pkg::CSEL_LSB] ==
                       dswd_pkg::CSEL_CHCTRL);

    always_ff @(posedge pclk or negedge presetn)
    begin
      if (!presetn)
        channel_output_code[ch] <= dswd_pkg::CODE_RST;
      else if (hit && rsel == dswd_pkg::RSEL_CODE)
        channel_output_code[ch] <= payload;
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
      if (!presetn)
        gain_trim[ch] <= dswd_pkg::GAIN_RST;
      else if ((hit && rsel == dswd_pkg::RSEL_GAIN) ||
               (wr_en && rsel == dswd_pkg::RSEL_GAIN_ALL))
        gain_trim[ch] <= payload;
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
      if (!presetn)
        offset_trim[ch] <= dswd_pkg::OFS_RST;
      else if ((hit && rsel == dswd_pkg::RSEL_OFS) ||
               (wr_en && rsel == dswd_pkg::RSEL_OFS_ALL))
        offset_trim[ch] <= payload;
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
      if (!presetn)
        clear_code[ch] <= dswd_pkg::CLR_RST;
      else if (hit && rsel == dswd_pkg::RSEL_CLR)
        clear_code[ch] <= payload;
    end

    // Range and output enable live here; a range change rewrites this and the ctrl_wr_target/ctrl_wr_channel/ctrl_wr_data report, not boost_config
    always_ff @(posedge pclk or negedge presetn)
    begin
      if (!presetn)
        channel_control[ch] <= dswd_pkg::CTRL_RST;
      else if (ctrl_hit)
        channel_control[ch] <= cmd_word[dswd_pkg::CDATA_MSB:0];
    end
  end

  // Boost settings change only on their own target, never on a range change
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      boost_config <= dswd_pkg::CTRL_RST;
    else if (wr_en && rsel == dswd_pkg::RSEL_CTRL &&
             cmd_word[dswd_pkg::CSEL_MSB:dswd_pkg::CSEL_LSB] == dswd_pkg::CSEL_BOOST)
      boost_config <= cmd_word[dswd_pkg::CDATA_MSB:0];
  end

  // Every control write is also reported for targets held outside this block
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      ctrl_wr_pulse   <= 1'b0;
      ctrl_wr_target  <= '0;
      ctrl_wr_channel <= '0;
      ctrl_wr_data    <= '0;
    end
    else
    begin
      ctrl_wr_pulse <= wr_en && rsel == dswd_pkg::RSEL_CTRL;
      if (wr_en && rsel == dswd_pkg::RSEL_CTRL)
      begin
        ctrl_wr_target  <= cmd_word[dswd_pkg::CSEL_MSB:dswd_pkg::CSEL_LSB];
        ctrl_wr_channel <= chan;
        ctrl_wr_data    <= cmd_word[dswd_pkg::CDATA_MSB:0];
      end
    end
  end

  // Select 001 reaches no register: none of the decodes above matches it

  // Reads latch the command word into read_word; readback framing is handled elsewhere
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      read_pulse <= 1'b0;
      read_word  <= '0;
    end
    else
    begin
      read_pulse <= frame_ok && addr_hit && cmd_word[dswd_pkg::RW_POS];
      if (frame_ok && addr_hit && cmd_word[dswd_pkg::RW_POS])
        read_word <= cmd_word;
    end
  end

  // Check byte is exposed; the check itself is computed outside
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      check_code <= '0;
    else if (frame_ok && frame_check_enable)
      check_code <= shift_ff[7:0];
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      frame_drop_pulse <= 1'b0;
    else
      frame_drop_pulse <= frame_end && (count_ff != frame_len);
  end
endmodule : dswd_device
`default_nettype wire

// file: hw/dswd_host.sv
`timescale 1ns/1ps
`default_nettype none
module dswd_host #(
  parameter int SETTLE_CYC = dswd_pkg::SETTLE_CYC,
  parameter int SCLK_HALF  = dswd_pkg::SCLK_HALF
) (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output var  logic [31:0] prdata,
  output var  logic        pready,
  output var  logic        pslverr,
  dswd_if.host_mp          link
);
  typedef enum logic [1:0] {IDLE, SHIFT, TAIL, GAP} dswd_state_type;

  dswd_state_type state_ff;
  logic [23:0] word_ff;
  logic [7:0]  check_ff;
  logic        chk_en_ff;
  logic        pend_ff;
  logic [31:0] shift_ff;
  logic [5:0]  left_ff;
  logic [15:0] div_ff;
  logic [31:0] settle_ff;
  logic        is_code_ff;
  logic        tick;
  logic        wr_acc;
  logic        mapped;
  logic        launch;
  logic        held;

  assign pready = 1'b1;
  assign mapped = paddr == dswd_pkg::A_CTRL || paddr == dswd_pkg::A_WORD ||
                  paddr == dswd_pkg::A_CHECK || paddr == dswd_pkg::A_STAT;
  assign pslverr = psel && penable && !mapped;
  assign wr_acc  = psel && penable && pwrite && mapped;
  assign tick    = div_ff == 16'(SCLK_HALF - 1);
  // Control writes wait out the settling time after a code write
  assign held    = word_ff[dswd_pkg::RSEL_MSB:dswd_pkg::RSEL_LSB] == dswd_pkg::RSEL_CTRL &&
                   settle_ff != '0;
  assign launch  = state_ff == IDLE && pend_ff && !held;

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      word_ff  <= '0;
      check_ff <= '0;
      chk_en_ff <= 1'b0;
    end
    else if (wr_acc)
    begin
      if (paddr == dswd_pkg::A_WORD)
        word_ff <= pwdata[23:0];
      if (paddr == dswd_pkg::A_CHECK)
        check_ff <= pwdata[7:0];
      if (paddr == dswd_pkg::A_CTRL)
        chk_en_ff <= pwdata[dswd_pkg::CHK_EN_POS];
    end
  end

  // A new start wins over the clear of the one being launched
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      pend_ff <= 1'b0;
    else if (wr_acc && paddr == dswd_pkg::A_CTRL && pwdata[dswd_pkg::START_POS])
      pend_ff <= 1'b1;
    else if (launch)
      pend_ff <= 1'b0;
  end

  // Read data sampled in the setup cycle so it stands through the access
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      prdata <= '0;
    else if (psel && !penable)
    begin
      unique case (paddr)
        dswd_pkg::A_CTRL:  prdata <= {30'h0, chk_en_ff, 1'b0};
        dswd_pkg::A_WORD:  prdata <= {8'h00, word_ff};
        dswd_pkg::A_CHECK: prdata <= {24'h000000, check_ff};
        dswd_pkg::A_STAT:  prdata <= {29'h0, pend_ff, settle_ff != '0, state_ff != IDLE};
        default:           prdata <= '0;
      endcase
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      div_ff <= '0;
    else if (state_ff == IDLE || tick)
      div_ff <= '0;
    else
      div_ff <= div_ff + 16'h0001;
  end

  // Bits change after the rising serial edge and are taken on the falling one
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      state_ff    <= IDLE;
      link.sclk   <= 1'b1;
      link.sync_n <= 1'b1;
      link.sdin   <= 1'b0;
      shift_ff    <= '0;
      left_ff     <= '0;
      is_code_ff  <= 1'b0;
    end
    else
    begin
      unique case (state_ff)
        IDLE:
          if (launch)
          begin
            shift_ff    <= chk_en_ff ? {word_ff, check_ff} : {word_ff, 8'h00};
            link.sdin   <= word_ff[23];
            left_ff     <= chk_en_ff ? 6'(dswd_pkg::CHECKED_BITS)
                                     : 6'(dswd_pkg::CMD_BITS);
            link.sync_n <= 1'b0;
            is_code_ff  <= !word_ff[dswd_pkg::RW_POS] &&
                           word_ff[dswd_pkg::RSEL_MSB:dswd_pkg::RSEL_LSB] == dswd_pkg::RSEL_CODE;
            state_ff    <= SHIFT;
          end
        SHIFT:
          if (tick)
          begin
            if (link.sclk)
            begin
              link.sclk <= 1'b0;
              left_ff   <= left_ff - 6'h01;
            end
            else if (left_ff == '0)
            begin
              link.sclk <= 1'b1;
              state_ff  <= TAIL;
            end
            else
            begin
              link.sclk <= 1'b1;
              shift_ff  <= {shift_ff[30:0], 1'b0};
              link.sdin <= shift_ff[30];
            end
          end
        TAIL:
          if (tick)
          begin
            link.sync_n <= 1'b1;
            state_ff    <= GAP;
          end
        GAP:
          if (tick)
            state_ff <= IDLE;
      endcase
    end
  end

  // Settling window opens when a code write has been sent
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      settle_ff <= '0;
    else if (state_ff == TAIL && tick && is_code_ff)
      settle_ff <= 32'(SETTLE_CYC);
    else if (settle_ff != '0)
      settle_ff <= settle_ff - 32'h1;
  end
endmodule : dswd_host
`default_nettype wire

// file: bench/dswd_assertions.sv
`timescale 1ns/1ps
`default_nettype none
module dswd_assertions (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic sclk,
  input wire logic sync_n,
  input wire logic sdin,
  input wire logic frame_check_enable
);
  logic       sclk_q_ff;
  logic       sync_q_ff;
  logic [5:0] bits_ff;

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      sclk_q_ff <= 1'b1;
      sync_q_ff <= 1'b1;
    end
    else
    begin
      sclk_q_ff <= sclk;
      sync_q_ff <= sync_n;
    end
  end

  // Falling sclk edges inside the frame; held until the cycle after sync_n rises
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      bits_ff <= 6'h00;
    else if (sync_n && sync_q_ff)
      bits_ff <= 6'h00;
    else if (!sync_n && sclk_q_ff && !sclk)
      bits_ff <= bits_ff + 6'h01;
  end

  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);

  sequence s_open;
    $fell(sync_n);
  endsequence
  sequence s_close;
    $rose(sync_n);
  endsequence
  sequence s_low_half;
    !sclk[*4] ##1 sclk;
  endsequence

  property p_idle_high;
    sync_n |-> sclk;
  endproperty
  a_idle_high: assert property (p_idle_high)
    else $error("sclk low outside a frame");
  property p_bounded;
    s_open |-> ##[1:400] s_close;
  endproperty
  a_bounded: assert property (p_bounded)
    else $error("frame never closed");
  property p_len24;
    s_close and !frame_check_enable |-> bits_ff == 6'd24;
  endproperty
  a_len24: assert property (p_len24)
    else $error("plain frame bit count wrong");
  property p_len32;
    s_close and frame_check_enable |-> bits_ff == 6'd32;
  endproperty
  a_len32: assert property (p_len32)
    else $error("checked frame bit count wrong");
  property p_low_half;
    $fell(sclk) |-> s_low_half;
  endproperty
  a_low_half: assert property (p_low_half)
    else $error("sclk low phase length wrong");
  property p_sdin_hold;
    !sclk && !$past(sclk) |-> $stable(sdin);
  endproperty
  a_sdin_hold: assert property (p_sdin_hold)
    else $error("sdin moved while sclk low");
  property p_tail;
    s_close |-> sclk && $past(sclk);
  endproperty
  a_tail: assert property (p_tail)
    else $error("frame closed with sclk low");
  property p_gap;
    s_close |-> sync_n[*4];
  endproperty
  a_gap: assert property (p_gap)
    else $error("gap between frames too short");
endmodule : dswd_assertions
`default_nettype wire

// file: bench/testbench.sv
`timescale 1ns/1ps
`default_nettype none
module testbench;
  logic             pclk;
  logic             presetn;
  logic             psel;
  logic             penable;
  logic             pwrite;
  logic [7:0]       paddr;
  logic [31:0]      pwdata;
  logic [31:0]      prdata;
  logic             pready;
  logic             pslverr;
  logic             fce;
  logic [3:0][15:0] code, gain, ofs, clr, code2;
  logic [3:0][15:0] m_code, m_gain, m_ofs, m_clr;
  logic [3:0][12:0] chctl, m_ctl;
  logic [12:0]      boost, m_boost;
  logic [23:0]      rd_word, w;
  logic [7:0]       chk_code;
  logic             drop2;
  logic [1:0]       strap;
  logic             ctl_pulse;
  logic             rd_pulse;
  logic [2:0]       wr_tgt;
  logic [1:0]       wr_ch;
  logic [12:0]      wr_data;
  logic [31:0]      seed, q;
  logic             e;
  int               err_count, total_checks, cycles, drop_cnt, rd_cnt, ctl_cnt, k, n0;

  dswd_if link ();
  dswd_if link2 ();
  dswd_host #(.SETTLE_CYC(50), .SCLK_HALF(4)) dswd_host_inst (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .link(link));
  dswd_device dswd_device_inst (
    .pclk(pclk), .presetn(presetn), .link(link),
    .strap_pin_hi(strap[1]), .strap_pin_lo(strap[0]),
    .frame_check_enable(fce), .channel_output_code(code), .gain_trim(gain),
    .offset_trim(ofs), .clear_code(clr), .channel_control(chctl), .boost_config(boost),
    .ctrl_wr_pulse(ctl_pulse), .ctrl_wr_target(wr_tgt), .ctrl_wr_channel(wr_ch),
    .ctrl_wr_data(wr_data), .read_pulse(rd_pulse), .read_word(rd_word),
    .check_code(chk_code), .frame_drop_pulse());
  // Second device faces the bench driver so broken frames can be sent on purpose
  dswd_device dswd_device2_inst (
    .pclk(pclk), .presetn(presetn), .link(link2), .strap_pin_hi(1'b0), .strap_pin_lo(1'b0),
    .frame_check_enable(1'b0), .channel_output_code(code2), .gain_trim(), .offset_trim(),
    .clear_code(), .channel_control(), .boost_config(), .ctrl_wr_pulse(),
    .ctrl_wr_target(), .ctrl_wr_channel(), .ctrl_wr_data(), .read_pulse(), .read_word(),
    .check_code(), .frame_drop_pulse(drop2));
  dswd_assertions dswd_assertions_inst (
    .pclk(pclk), .presetn(presetn), .sclk(link.sclk), .sync_n(link.sync_n),
    .sdin(link.sdin), .frame_check_enable(fce));

  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction : lfsr

  function automatic void model(input logic [23:0] x);
    logic [1:0] ch;
    ch = x[17:16];
    if (x[23] || x[22:21] != strap)
      return;
    case (x[20:18])
      dswd_pkg::RSEL_CODE:     m_code[ch] = x[15:0];
      dswd_pkg::RSEL_GAIN:     m_gain[ch] = x[15:0];
      dswd_pkg::RSEL_GAIN_ALL: m_gain = {4{x[15:0]}};
      dswd_pkg::RSEL_OFS:      m_ofs[ch] = x[15:0];
      dswd_pkg::RSEL_OFS_ALL:  m_ofs = {4{x[15:0]}};
      dswd_pkg::RSEL_CLR:      m_clr[ch] = x[15:0];
      dswd_pkg::RSEL_CTRL:
        if (x[15:13] == dswd_pkg::CSEL_CHCTRL)
          m_ctl[ch] = x[12:0];
        else if (x[15:13] == dswd_pkg::CSEL_BOOST)
          m_boost = x[12:0];
      default: ;
    endcase
  endfunction : model

  task automatic check(input string nm, input logic [31:0] exp, input logic [31:0] got);
    total_checks++;
    if (got !== exp)
    begin
      err_count++;
      $display("mismatch %s expected %h seen %h", nm, exp, got);
    end
  endtask : check

  task automatic end_of_test();
    $display("checks %0d mismatches %0d", total_checks, err_count);
    if (err_count == 0 && total_checks > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask : end_of_test

  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1)
      @(posedge pclk);
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask : apb

  task automatic send(input logic [23:0] x, input logic chk, input logic [7:0] cb);
    int n;
    fce <= chk;
    apb(1'b1, dswd_pkg::A_WORD, {8'h00, x});
    apb(1'b1, dswd_pkg::A_CHECK, {24'h000000, cb});
    apb(1'b1, dswd_pkg::A_CTRL, {30'h00000000, chk, 1'b1});
    n = 0;
    q = 32'hFFFFFFFF;
    while ((q[dswd_pkg::BUSY_POS] !== 1'b0 || q[dswd_pkg::PEND_POS] !== 1'b0) && n < 4000)
    begin
      apb(1'b0, dswd_pkg::A_STAT, 32'h00000000);
      n++;
    end
    // A frame that never finishes counts against the run
    check("frame_done", 32'h00000000, {31'h00000000, n >= 4000});
    repeat (8) @(posedge pclk);
    model(x);
    if (chk && !x[23] && x[22:21] == strap)
      check("check_code", {24'h000000, cb}, {24'h000000, chk_code});
  endtask : send

  task automatic cmp_all();
    int i;
    for (i = 0; i < 4; i++)
    begin
      check("code", {16'h0000, m_code[i]}, {16'h0000, code[i]});
      check("gain", {16'h0000, m_gain[i]}, {16'h0000, gain[i]});
      check("offset", {16'h0000, m_ofs[i]}, {16'h0000, ofs[i]});
      check("clear", {16'h0000, m_clr[i]}, {16'h0000, clr[i]});
      check("chctl", {19'h00000, m_ctl[i]}, {19'h00000, chctl[i]});
    end
    check("boost", {19'h00000, m_boost}, {19'h00000, boost});
  endtask : cmp_all

  // A released data line shows the inverse of its last bit, never a stale copy
  task automatic raw(input int n, input logic [31:0] x);
    int i;
    link2.sync_n <= 1'b0;
    for (i = n - 1; i >= 0; i--)
    begin
      link2.sdin <= x[i];
      repeat (4) @(posedge pclk);
      link2.sclk <= 1'b0;
      repeat (4) @(posedge pclk);
      link2.sclk <= 1'b1;
    end
    repeat (4) @(posedge pclk);
    link2.sync_n <= 1'b1;
    link2.sdin <= ~x[0];
    repeat (12) @(posedge pclk);
  endtask : raw

  initial
  begin
    pclk = 1'b0;
    forever #2 pclk = ~pclk;
  end

  always @(posedge pclk)
  begin
    cycles++;
    if (drop2 === 1'b1)
      drop_cnt++;
    if (rd_pulse === 1'b1)
      rd_cnt++;
    if (ctl_pulse === 1'b1)
      ctl_cnt++;
    if (cycles == 60000)
    begin
      err_count++;
      end_of_test();
    end
  end

  initial
  begin
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h00000000;
    fce = 1'b0;
    link2.sclk = 1'b1;
    link2.sync_n = 1'b1;
    link2.sdin = 1'b0;
    strap = 2'b10;
    seed = 32'hF8241746;
    m_code = {4{dswd_pkg::CODE_RST}};
    m_gain = {4{dswd_pkg::GAIN_RST}};
    m_ofs = {4{dswd_pkg::OFS_RST}};
    m_clr = {4{dswd_pkg::CLR_RST}};
    m_ctl = {4{dswd_pkg::CTRL_RST}};
    m_boost = dswd_pkg::CTRL_RST;
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    repeat (4) @(posedge pclk);
    cmp_all();
    apb(1'b0, 8'h10, 32'h00000000);
    check("unmapped_err", 32'h00000001, {31'h00000000, e});
    check("unmapped_data", 32'h00000000, q);
    for (k = 0; k < 8; k++)
    begin
      send({1'b0, 2'b10, k[2:0], k[1:0], 3'h2, 13'h1FFF - k[12:0]}, k[0], 8'hA5 ^ k[7:0]);
      cmp_all();
    end
    for (k = 0; k < 4; k++)
    begin
      send({1'b0, 2'b10, dswd_pkg::RSEL_CODE, k[1:0], 16'hFFFF}, 1'b1, k[7:0]);
      send({1'b0, k[1:0] ^ 2'b11, dswd_pkg::RSEL_GAIN_ALL, 2'b00, 16'h0000}, 1'b0, 8'h00);
      cmp_all();
    end
    w = {1'b1, 2'b10, dswd_pkg::RSEL_CODE, 2'b01, 16'h1234};
    n0 = rd_cnt;
    send(w, 1'b0, 8'h00);
    check("read_word", {8'h00, w}, {8'h00, rd_word});
    check("read_pulse", 32'h00000001, {31'h00000000, n0 + 1 == rd_cnt});
    cmp_all();
    n0 = ctl_cnt;
    send({1'b0, 2'b10, dswd_pkg::RSEL_CTRL, 2'b00, dswd_pkg::CSEL_BOOST, 13'h1ABC}, 1'b0, 8'h00);
    check("ctrl_pulse", 32'h00000001, {31'h00000000, n0 + 1 == ctl_cnt});
    check("ctrl_target", {29'h00000000, dswd_pkg::CSEL_BOOST}, {29'h00000000, wr_tgt});
    check("ctrl_data", 32'h00001ABC, {19'h00000, wr_data});
    send({1'b0, 2'b10, dswd_pkg::RSEL_CTRL, 2'b01, dswd_pkg::CSEL_CHCTRL, 13'h0F00}, 1'b0, 8'h00);
    check("ctrl_channel", 32'h00000001, {30'h00000000, wr_ch});
    send({1'b0, 2'b10, dswd_pkg::RSEL_CODE, 2'b01, 16'h8000}, 1'b0, 8'h00);
    // The settling window opened by the code write is still running here
    apb(1'b0, dswd_pkg::A_STAT, 32'h00000000);
    check("settling", 32'h00000001, {31'h00000000, q[dswd_pkg::SETTLE_POS]});
    send({1'b0, 2'b10, dswd_pkg::RSEL_CTRL, 2'b01, dswd_pkg::CSEL_CHCTRL, 13'h0F01}, 1'b0, 8'h00);
    cmp_all();
    for (k = 0; k < 16; k++)
    begin
      seed = lfsr(seed);
      w = seed[23:0];
      strap <= seed[28:27];
      if (seed[31:30] != 2'b00)
        w[22:21] = seed[28:27];
      send(w, seed[29], seed[31:24]);
      cmp_all();
    end
    for (k = 23; k <= 25; k += 2)
    begin
      n0 = drop_cnt;
      raw(k, 32'h0000C3C3);
      check("drop", 32'h00000001, n0 + 1 == drop_cnt);
      check("partial", 32'h00000000, {16'h0000, code2[0]});
    end
    raw(24, 32'h0000C3C3);
    check("full", 32'h0000C3C3, {16'h0000, code2[0]});
    end_of_test();
  end
endmodule : testbench
`default_nettype wire
